// ===== rtl/thl_defs.svh
// Register offsets, field positions and reset values of the trip history logger.
`ifndef THL_DEFS_SVH
`define THL_DEFS_SVH
`define THL_AW         9
`define THL_OFS_LOGCTL 9'h000
`define THL_OFS_TBC    9'h004
`define THL_OFS_STAT   9'h008
`define THL_OFS_CMD    9'h00c
`define THL_OFS_DTSEL  9'h010
`define THL_REG_CODE   3'h1
`define THL_REG_STAMP  3'h2
`define THL_REG_SUB    3'h3
`define THL_REG_MON    3'h4
`define THL_REG_CTL    3'h0
`define THL_REG_MON_HI 3'h5
`define THL_MIDX_HI    6
`define THL_BYTE_HI    7
`define THL_BE_LOW     0
`define THL_DTSEL_BIT  0
`define THL_SUB_NONE   8'h00
`define THL_SLOT_MAX   16
`define THL_MON_MAX    32
`define THL_WORD_W     32
`define THL_RGN_HI     8
`define THL_RGN_LO     6
`define THL_IDX_HI     5
`define THL_IDX_LO     2
`define THL_LOG_CLEAR  8'hff
`define THL_TBC_NOFRZ  4
`define THL_CMD_CLRTRP 0
`define THL_CMD_PWREN  1
`define THL_ST_TRIP    0
`define THL_ST_PWR     1
`define THL_ST_FRZ     2
`define THL_RST_BYTE   8'h00
`endif

// ===== rtl/thl_pkg.sv
// Types shared by the trip history logger.
package thl_pkg;
  typedef logic [7:0]  thl_byte_t;
  typedef logic [31:0] thl_word_t;
  typedef enum logic {
    THL_SRC_PRIMARY,
    THL_SRC_ALTERNATE
  } thl_dtsrc_e;
endpackage

// ===== rtl/thl_logger.sv
// Trip history logger with power disable, monitor freeze and Avalon-MM registers.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`include "thl_defs.svh"
module thl_logger
  import thl_pkg::*;
#(
  parameter int SLOTS  = 10,
  parameter int CODE_W = 8,
  parameter int MON_N  = 18,
  parameter int MON_W  = 16
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic                   trip_i,
  input  wire logic [CODE_W-1:0]      trip_code_i,
  input  wire logic                   trip_has_sub_i,
  input  wire logic [7:0]             trip_sub_i,
  input  wire logic [15:0]            date_pri_i,
  input  wire logic [15:0]            time_pri_i,
  input  wire logic [15:0]            date_alt_i,
  input  wire logic [15:0]            time_alt_i,
  input  wire logic [MON_N*MON_W-1:0] mon_live_i,
  input  wire logic [`THL_AW-1:0]     avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  output logic                        pwr_enable_o,
  output logic                        tripped_o,
  output logic [MON_N*MON_W-1:0]      mon_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  // Values that the index fields or the read path cannot serve are refused.
  if (SLOTS < 1 || SLOTS > `THL_SLOT_MAX) begin : g_bad_slots
    $error("SLOTS must lie between 1 and 16.");
  end
  if (MON_N < 1 || MON_N > `THL_MON_MAX) begin : g_bad_mon_n
    $error("MON_N must lie between 1 and 32.");
  end
  if (CODE_W < 1 || CODE_W > `THL_WORD_W) begin : g_bad_code_w
    $error("CODE_W must lie between 1 and 32.");
  end
  if (MON_W < 1 || MON_W > `THL_WORD_W) begin : g_bad_mon_w
    $error("MON_W must lie between 1 and 32.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake.

  // Bus decode.
  logic                    wait_q;
  logic                    req;
  logic                    acc;
  logic                    wr_acc;
  logic [2:0]              rgn;
  logic [3:0]              idx;
  logic [4:0]              midx;
  logic                    sel_logctl;
  logic                    sel_tbc;
  logic                    sel_cmd;
  logic                    sel_dtsel;

  // Settings, trip state and command pulses.
  thl_byte_t               logctl_q;
  thl_byte_t               tbc_q;
  thl_dtsrc_e              dtsel_q;
  logic                    trip_q;
  logic                    pwr_q;
  logic                    frz;
  logic                    clr_log;
  logic                    clr_trip;
  logic                    pwr_cmd;

  // Log storage.
  logic [CODE_W-1:0]       code_q  [SLOTS];
  logic [31:0]             stamp_q [SLOTS];
  logic [7:0]              sub_q   [SLOTS];
  logic [31:0]             stamp_now;
  logic [7:0]              sub_now;

  // Read path.
  thl_word_t               rdata_d;
  thl_word_t               rdata_q;

  // Request decode; an access is accepted in the cycle in which waitrequest is low.
  assign req    = avs_read_i | avs_write_i;
  assign acc    = req & ~wait_q;
  assign wr_acc = acc & avs_write_i & avs_byteenable_i[`THL_BE_LOW];
  assign rgn    = avs_address_i[`THL_RGN_HI:`THL_RGN_LO];
  assign idx    = avs_address_i[`THL_IDX_HI:`THL_IDX_LO];
  assign midx   = avs_address_i[`THL_MIDX_HI:`THL_IDX_LO];

  // Waitrequest drops for one cycle, one edge after a request appears.
  // Every access thus takes two cycles and takes effect only in the second,
  // so a request held one cycle past its acceptance is not served twice.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control settings.

  // Register selects for accepted writes.
  assign sel_logctl = wr_acc && avs_address_i == `THL_OFS_LOGCTL;
  assign sel_tbc    = wr_acc && avs_address_i == `THL_OFS_TBC;
  assign sel_cmd    = wr_acc && avs_address_i == `THL_OFS_CMD;
  assign sel_dtsel  = wr_acc && avs_address_i == `THL_OFS_DTSEL;

  // Command pulses last one cycle and are never stored.
  assign clr_log  = sel_logctl && avs_writedata_i[`THL_BYTE_HI:0] == `THL_LOG_CLEAR;
  assign clr_trip = sel_cmd && avs_writedata_i[`THL_CMD_CLRTRP];
  assign pwr_cmd  = sel_cmd && avs_writedata_i[`THL_CMD_PWREN];

  // Stored settings; the log control value reads back as written.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      logctl_q <= `THL_RST_BYTE;
      tbc_q    <= `THL_RST_BYTE;
      dtsel_q  <= THL_SRC_PRIMARY;
    end else begin
      if (sel_logctl) begin
        logctl_q <= avs_writedata_i[`THL_BYTE_HI:0];
      end
      if (sel_tbc) begin
        tbc_q <= avs_writedata_i[`THL_BYTE_HI:0];
      end
      if (sel_dtsel) begin
        dtsel_q <= thl_dtsrc_e'(avs_writedata_i[`THL_DTSEL_BIT]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip state and power output.

  // The trip flag also drives the freeze and the power interlock below.
  // A trip arriving with a clear command keeps the drive tripped.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      trip_q <= 1'b0;
    end else if (trip_i) begin
      trip_q <= 1'b1;
    end else if (clr_trip) begin
      trip_q <= 1'b0;
    end
  end

  // Power drops on a trip and returns only on a separate enable.
  // Clearing a trip never restores power by itself, so the load stays free until asked.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_q <= 1'b0;
    end else if (trip_i) begin
      pwr_q <= 1'b0;
    end else if (pwr_cmd && !trip_q) begin
      pwr_q <= 1'b1;
    end
  end

  assign pwr_enable_o = pwr_q;
  assign tripped_o    = trip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Monitor freeze.

  // Holding starts in the trip cycle, so the last pre-trip sample stays.
  // With the no-freeze bit set the values track live data even while tripped.
  assign frz = (trip_i | trip_q) & ~tbc_q[`THL_TBC_NOFRZ];

  generate
    for (genvar m = 0; m < MON_N; m++) begin : g_mon
      // Each value tracks live data unless frozen.
      // Reset clears the held copies so no stale value is read after reset.
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          mon_o[m*MON_W +: MON_W] <= '0;
        end else if (!frz) begin
          mon_o[m*MON_W +: MON_W] <= mon_live_i[m*MON_W +: MON_W];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Trip history logs.

  // Stamp from the selected source; sub-code zero when absent.
  assign stamp_now = (dtsel_q == THL_SRC_ALTERNATE) ? {date_alt_i, time_alt_i}
                                                    : {date_pri_i, time_pri_i};
  assign sub_now   = trip_has_sub_i ? trip_sub_i : `THL_SUB_NONE;

  // A log clear in the trip cycle empties the older slots but keeps the new entry,
  // so the trip that arrives with the clear is never lost.
  generate
    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      // Slot zero takes the new trip; others take their neighbour.
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          code_q[s]  <= '0;
          stamp_q[s] <= '0;
          sub_q[s]   <= '0;
        end else if (trip_i) begin
          if (s == 0) begin
            code_q[s]  <= trip_code_i;
            stamp_q[s] <= stamp_now;
            sub_q[s]   <= sub_now;
          end else if (clr_log) begin
            code_q[s]  <= '0;
            stamp_q[s] <= '0;
            sub_q[s]   <= '0;
          end else begin
            code_q[s]  <= code_q[s-1];
            stamp_q[s] <= stamp_q[s-1];
            sub_q[s]   <= sub_q[s-1];
          end
        end else if (clr_log) begin
          code_q[s]  <= '0;
          stamp_q[s] <= '0;
          sub_q[s]   <= '0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Unmapped addresses and reserved bits read as zero.
  // Monitor values span two address regions and use the wider index.
  always_comb begin
    rdata_d = '0;
    case (rgn)
      `THL_REG_CTL: begin
        case (avs_address_i)
          `THL_OFS_LOGCTL: rdata_d[`THL_BYTE_HI:0] = logctl_q;
          `THL_OFS_TBC:    rdata_d[`THL_BYTE_HI:0] = tbc_q;
          `THL_OFS_DTSEL:  rdata_d[`THL_DTSEL_BIT] = dtsel_q;
          `THL_OFS_STAT: begin
            rdata_d[`THL_ST_TRIP] = trip_q;
            rdata_d[`THL_ST_PWR]  = pwr_q;
            rdata_d[`THL_ST_FRZ]  = frz;
          end
          default: rdata_d = '0;
        endcase
      end
      `THL_REG_CODE: begin
        if (32'(idx) < SLOTS) begin
          rdata_d[CODE_W-1:0] = code_q[idx];
        end
      end
      `THL_REG_STAMP: begin
        if (32'(idx) < SLOTS) begin
          rdata_d = stamp_q[idx];
        end
      end
      `THL_REG_SUB: begin
        if (32'(idx) < SLOTS) begin
          rdata_d[`THL_BYTE_HI:0] = sub_q[idx];
        end
      end
      `THL_REG_MON, `THL_REG_MON_HI: begin
        if (32'(midx) < MON_N) begin
          rdata_d[MON_W-1:0] = mon_o[midx*MON_W +: MON_W];
        end
      end
      default: rdata_d = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read register.

  // Read data is loaded with the cycle in which waitrequest drops.
  // Loading only while waitrequest is high keeps the value steady while the master takes it.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

endmodule

// ===== verification/thl_logger_monitor.sv
// Concurrent checks on the trip history logger ports.
`timescale 1ns/1ps
`include "thl_defs.svh"
module thl_logger_monitor #(
  parameter int MON_N = 18,
  parameter int MON_W = 16
) (
  input wire logic                   clk_sys_i,
  input wire logic                   rst_i,
  input wire logic                   trip_i,
  input wire logic [MON_N*MON_W-1:0] mon_live_i,
  input wire logic [`THL_AW-1:0]     avs_address_i,
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic [31:0]            avs_writedata_i,
  input wire logic [3:0]             avs_byteenable_i,
  input wire logic                   avs_waitrequest_o,
  input wire logic                   pwr_enable_o,
  input wire logic                   tripped_o,
  input wire logic [MON_N*MON_W-1:0] mon_o
);
  logic done_w;
  logic wr_cmd;
  logic nofrz_q;
  // Writes with byte lane 0 enabled that complete at this edge, and those aimed at the command register.
  assign done_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign wr_cmd = done_w && avs_address_i == `THL_OFS_CMD;
  // Shadow of the no-freeze bit, updated at the same edge as the block's own copy.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      nofrz_q <= 1'b0;
    end else if (done_w && avs_address_i == `THL_OFS_TBC) begin
      nofrz_q <= avs_writedata_i[`THL_TBC_NOFRZ];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_answer)
    else $error("bus answer late");
  a_trip_kills_power: assert property (trip_i |=> tripped_o && !pwr_enable_o)
    else $error("power left on");
  a_trip_sticky: assert property (tripped_o && !(wr_cmd && avs_writedata_i[0]) |=> tripped_o)
    else $error("trip dropped");
  a_clear_releases: assert property (wr_cmd && avs_writedata_i[0] && !trip_i |=> !tripped_o)
    else $error("trip kept");
  a_pwr_needs_cmd: assert property ($rose(pwr_enable_o) |-> $past(wr_cmd && avs_writedata_i[1] && !tripped_o))
    else $error("power on unasked");
  a_mon_frozen: assert property ((trip_i || tripped_o) && !nofrz_q |=> $stable(mon_o))
    else $error("monitor moved");
  a_mon_tracks: assert property (!trip_i && !tripped_o |=> mon_o == $past(mon_live_i))
    else $error("monitor stale");
  a_nofrz_tracks: assert property (nofrz_q |=> mon_o == $past(mon_live_i))
    else $error("monitor frozen");
endmodule
bind thl_logger thl_logger_monitor #(
  .MON_N(MON_N),
  .MON_W(MON_W)
) thl_logger_monitor_i (
  .clk_sys_i         (clk_sys_i),
  .rst_i             (rst_i),
  .trip_i            (trip_i),
  .mon_live_i        (mon_live_i),
  .avs_address_i     (avs_address_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_writedata_i   (avs_writedata_i),
  .avs_byteenable_i  (avs_byteenable_i),
  .avs_waitrequest_o (avs_waitrequest_o),
  .pwr_enable_o      (pwr_enable_o),
  .tripped_o         (tripped_o),
  .mon_o             (mon_o)
);

// ===== verification/thl_host.sv
// Bus master model of the host that reads and writes the logger.
`timescale 1ns/1ps
module thl_host (
  input  wire logic        clk_sys_i,
  input  wire logic        avs_waitrequest_o,
  input  wire logic [31:0] avs_readdata_o,
  output logic      [8:0]  avs_address_i,
  output logic             avs_read_i,
  output logic             avs_write_i,
  output logic      [31:0] avs_writedata_i,
  output logic      [3:0]  avs_byteenable_i
);
  // Idle bus at time zero.
  initial begin
    avs_address_i = 9'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
  end
  // One access; held until waitrequest is seen low, then released with stale lines inverted.
  task automatic access(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    avs_address_i <= ~a;
    avs_writedata_i <= ~d;
  endtask
  // Byte enables for the accesses that follow; changed only between accesses.
  task automatic set_be(input logic [3:0] be);
    avs_byteenable_i <= be;
  endtask
endmodule

// ===== verification/tb_thl_logger.sv
// Self-checking testbench for the trip history logger.
`timescale 1ns/1ps
`include "thl_defs.svh"
module tb_thl_logger;
  logic clk_sys_i, rst_i, trip_i, trip_has_sub_i, avs_read_i, avs_write_i;
  logic avs_waitrequest_o, pwr_enable_o, tripped_o;
  logic [7:0] trip_code_i, trip_sub_i, c;
  logic [15:0] date_pri_i, time_pri_i, date_alt_i, time_alt_i, mon_pat;
  logic [287:0] mon_live_i, mon_o;
  logic [8:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i;
  int errors, n_checks;
  // Trip side inputs follow the trip code so every log entry is predictable.
  assign date_pri_i = {8'h00, trip_code_i};
  assign time_pri_i = {8'h10, trip_code_i};
  assign date_alt_i = {8'ha0, trip_code_i};
  assign time_alt_i = {8'hb0, trip_code_i};
  assign trip_sub_i = trip_code_i + 8'h40;
  assign trip_has_sub_i = trip_code_i[0];
  assign mon_live_i = {18{mon_pat}};
  thl_logger thl_logger_i (.*);
  thl_host thl_host_i (.*);
  // Free running clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    thl_host_i.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] q;
    thl_host_i.access(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  // Trips with codes first to last on consecutive cycles.
  task automatic fire(input int first, input int last);
    for (int k = first; k <= last; k++) begin
      @(posedge clk_sys_i);
      trip_i <= 1'b1;
      trip_code_i <= 8'(k);
    end
    @(posedge clk_sys_i);
    trip_i <= 1'b0;
  endtask
  task automatic t_trip_log();
    rd(9'h1fc, 32'h0);
    rd(`THL_OFS_STAT, 32'h0);
    wr(`THL_OFS_CMD, 32'h2);
    rd(`THL_OFS_STAT, 32'h2);
    fire(1, 11);
    wr(`THL_OFS_DTSEL, 32'h1);
    fire(12, 12);
    rd(`THL_OFS_STAT, 32'h5);
    wr(`THL_OFS_CMD, 32'h2);
    rd(`THL_OFS_STAT, 32'h5);
    for (int i = 0; i < 10; i++) begin
      c = 8'(12 - i);
      rd(9'h040 + 9'(4 * i), {24'h0, c});
      rd(9'h0c0 + 9'(4 * i), c[0] ? {24'h0, c + 8'h40} : 32'h0);
      rd(9'h080 + 9'(4 * i), i == 0 ? {8'ha0, c, 8'hb0, c} : {8'h00, c, 8'h10, c});
    end
    rd(9'h068, 32'h0);
    wr(`THL_OFS_CMD, 32'h1);
    rd(`THL_OFS_STAT, 32'h0);
    wr(`THL_OFS_DTSEL, 32'h0);
  endtask
  task automatic t_freeze();
    wr(`THL_OFS_CMD, 32'h2);
    @(posedge clk_sys_i);
    mon_pat <= 16'h1234;
    fire(20, 20);
    mon_pat <= 16'h5678;
    rd(9'h144, 32'h1234);
    rd(9'h100, 32'h1234);
    wr(`THL_OFS_CMD, 32'h1);
    rd(9'h144, 32'h5678);
    wr(`THL_OFS_TBC, 32'h10);
    fire(21, 21);
    mon_pat <= 16'h9abc;
    rd(9'h144, 32'h9abc);
    rd(`THL_OFS_STAT, 32'h1);
    wr(`THL_OFS_CMD, 32'h1);
  endtask
  task automatic t_clear_logs();
    thl_host_i.set_be(4'he);
    wr(`THL_OFS_LOGCTL, 32'hff);
    thl_host_i.set_be(4'hf);
    rd(`THL_OFS_LOGCTL, 32'h0);
    rd(9'h040, 32'h15);
    rd(9'h044, 32'h14);
    wr(`THL_OFS_LOGCTL, 32'hff);
    rd(`THL_OFS_LOGCTL, 32'hff);
    for (int i = 0; i < 10; i++) begin
      rd(9'h040 + 9'(4 * i), 32'h0);
      rd(9'h080 + 9'(4 * i), 32'h0);
      rd(9'h0c0 + 9'(4 * i), 32'h0);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    rst_i = 1'b1;
    trip_i = 1'b0;
    trip_code_i = 8'h00;
    mon_pat = 16'h0000;
    errors = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_trip_log();
    t_freeze();
    t_clear_logs();
    close_out();
  end
  // Watchdog well beyond the few hundred bus cycles the scenarios need.
  initial begin
    #200us;
    errors++;
    close_out();
  end
endmodule
